// *** hdl/ali_indicator.sv ***
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ali_params.svh"
// Operation
// - yellow means red and green both lit
// - patterns built from fixed 125 ms slots
// - inactive or unpowered means both LEDs off
// - measurement-device fault shows long red blink
// - over-temperature shows the same long red blink
// - cell census error shows red/green alternating
// - thermistor census shows red/green alternating
// - unlocked configuration shows red/green alternating
// - discharging alone shows yellow blink
// - identity defaults to one, settable one to four
// - identity changes frame identifier and prompt
// - default 250 kbit/s, extended identifiers, rate configurable
// - bus termination switchable by configuration
// - loop outputs dry contact or open collector
// - power removed puts chain devices asleep
// - chain messages wake devices to ready
// - highest priority active alert with a pattern alone drives LED
module ali_indicator #(
   parameter int SLOT_CYCLES = `ALI_SLOT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [31:0] reg_rdata,
   input wire logic ctrl_active,
   input wire logic [`ALI_AL_W-1:0] alert_in,
   input wire logic loop_a_fault,
   input wire logic loop_b_fault,
   input wire logic chain_msg,
   output logic led_red,
   output logic led_green,
   output logic [28:0] can_id,
   output logic can_ext_id,
   output logic [15:0] can_bit_div,
   output logic can_term_en,
   output logic [7:0] prompt_suffix,
   output logic cell_loop_oc_mode,
   output logic cell_loop_out_a,
   output logic cell_loop_out_b,
   output logic chain_sleep
);
   // ----------------------------------------
   // register bus
   // ----------------------------------------
   logic [4:0] ctrl;
   logic [15:0] rate;
   logic [`ALI_SLOT_CNT_W-1:0] slot_cnt;
   logic slot_tick;
   ali_pkg::ali_pat_t pat;
   ali_pkg::ali_pat_t next_pat;
   logic [2:0] slot;
   logic rom_red;
   logic rom_green;
   logic led_gate;
   logic [1:0] id_m1;

   assign id_m1 = ctrl[`ALI_CTRL_ID_HI:`ALI_CTRL_ID_LO];
   assign led_gate = ctrl_active & ctrl[`ALI_CTRL_EN];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `ALI_CTRL_RST;
      end else if (reg_we && reg_addr == `ALI_OFF_CTRL) begin
         ctrl <= reg_wdata[4:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rate <= `ALI_RATE_RST;
      end else if (reg_we && reg_addr == `ALI_OFF_RATE) begin
         rate <= reg_wdata[15:0];
      end
   end

   // unmapped addresses read as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_re) begin
         unique case (reg_addr)
            `ALI_OFF_CTRL: reg_rdata <= {27'h0000000, ctrl};
            `ALI_OFF_RATE: reg_rdata <= {16'h0000, rate};
            `ALI_OFF_STAT: reg_rdata <= {23'h000000, chain_sleep, led_green,
                                         led_red, slot, pat};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // alert priority
   // ----------------------------------------
   // overvoltage-balance alert has no LED pattern, so it falls through
   always_comb begin
      if (alert_in[`ALI_AL_MDEV]) begin
         next_pat = ali_pkg::ALI_PAT_LRED;
      end else if (alert_in[`ALI_AL_CELLC]) begin
         next_pat = ali_pkg::ALI_PAT_ALT;
      end else if (alert_in[`ALI_AL_THC]) begin
         next_pat = ali_pkg::ALI_PAT_ALT;
      end else if (alert_in[`ALI_AL_OVT]) begin
         next_pat = ali_pkg::ALI_PAT_LRED;
      end else if (alert_in[`ALI_AL_HVC]) begin
         next_pat = ali_pkg::ALI_PAT_RED;
      end else if (alert_in[`ALI_AL_LVC]) begin
         next_pat = ali_pkg::ALI_PAT_RED;
      end else if (alert_in[`ALI_AL_UNLK]) begin
         next_pat = ali_pkg::ALI_PAT_ALT;
      end else if (alert_in[`ALI_AL_DIS]) begin
         next_pat = ali_pkg::ALI_PAT_YEL;
      end else begin
         next_pat = ali_pkg::ALI_PAT_GRN;
      end
   end

   // ----------------------------------------
   // slot timing
   // ----------------------------------------
   assign slot_tick = (slot_cnt == `ALI_SLOT_CNT_W'(SLOT_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt <= '0;
      end else if (slot_tick) begin
         slot_cnt <= '0;
      end else begin
         slot_cnt <= slot_cnt + `ALI_SLOT_CNT_W'(1);
      end
   end

   // pattern only switches on a boundary, so no slot is ever cut short
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pat <= ali_pkg::ALI_PAT_OFF;
         slot <= 3'h0;
      end else if (slot_tick) begin
         if (next_pat != pat) begin
            pat <= next_pat;
            slot <= 3'h0;
         end else begin
            slot <= slot + 3'h1;
         end
      end
   end

   ali_pattern_rom u_rom (
      .clk(clk),
      .rst_n(rst_n),
      .pat(pat),
      .slot(slot),
      .red(rom_red),
      .green(rom_green)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         led_red <= 1'b0;
         led_green <= 1'b0;
      end else begin
         led_red <= led_gate & rom_red;
         led_green <= led_gate & rom_green;
      end
   end

   // ----------------------------------------
   // identity and network settings
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         can_id <= `ALI_CAN_BASE + 29'h00000001;
         prompt_suffix <= 8'h00;
         can_ext_id <= 1'b1;
         can_bit_div <= `ALI_RATE_RST;
         can_term_en <= 1'b0;
      end else begin
         can_id <= `ALI_CAN_BASE + {27'h0000000, id_m1} + 29'h00000001;
         // identity one keeps the bare prompt
         prompt_suffix <= (id_m1 == `ALI_ID_RST) ? 8'h00 :
                          `ALI_ASCII_ZERO + {6'h00, id_m1} + 8'h01;
         can_ext_id <= 1'b1;
         can_bit_div <= rate;
         can_term_en <= ctrl[`ALI_CTRL_TERM];
      end
   end

   // ----------------------------------------
   // cell loop and chain power
   // ----------------------------------------
   // dry contact is closed in normal running and opens on fault
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cell_loop_oc_mode <= 1'b0;
         cell_loop_out_a <= 1'b0;
         cell_loop_out_b <= 1'b0;
      end else begin
         cell_loop_oc_mode <= ctrl[`ALI_CTRL_OC];
         if (!ctrl_active) begin
            cell_loop_out_a <= 1'b0;
            cell_loop_out_b <= 1'b0;
         end else if (ctrl[`ALI_CTRL_OC]) begin
            cell_loop_out_a <= loop_a_fault;
            cell_loop_out_b <= loop_b_fault;
         end else begin
            cell_loop_out_a <= ~loop_a_fault;
            cell_loop_out_b <= ~loop_b_fault;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chain_sleep <= 1'b1;
      end else if (!ctrl_active) begin
         chain_sleep <= 1'b1;
      end else if (chain_msg) begin
         chain_sleep <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_dark;
      !led_gate |=> !led_red && !led_green;
   endproperty
   a_dark: assert property (p_dark) else $error("led lit while inactive");

   property p_hold;
      $changed(led_red) && $past(led_gate) && $past(led_gate, 2) |-> $past(slot_tick, 3);
   endproperty
   a_hold: assert property (p_hold) else $error("red changed mid slot");

   property p_yellow;
      $past(pat) == ali_pkg::ALI_PAT_YEL |-> rom_red == rom_green;
   endproperty
   a_yellow: assert property (p_yellow) else $error("yellow not both");

   property p_long;
      alert_in[`ALI_AL_MDEV] |-> next_pat == ali_pkg::ALI_PAT_LRED;
   endproperty
   a_long: assert property (p_long) else $error("fault not long red");

   property p_ovt;
      alert_in[3:0] == 4'h8 |-> next_pat == ali_pkg::ALI_PAT_LRED;
   endproperty
   a_ovt: assert property (p_ovt) else $error("overtemp not long red");

   property p_alt;
      alert_in[1:0] == 2'h2 || alert_in[6:0] == 7'h40
         |-> next_pat == ali_pkg::ALI_PAT_ALT;
   endproperty
   a_alt: assert property (p_alt) else $error("census not alternating");

   property p_cut;
      alert_in[3:0] == 4'h0 && alert_in[5:4] != 2'h0 |-> next_pat == ali_pkg::ALI_PAT_RED;
   endproperty
   a_cut: assert property (p_cut) else $error("cutoff not red");

   property p_idle;
      alert_in[6:0] == 7'h00 |-> next_pat == (alert_in[`ALI_AL_DIS] ?
         ali_pkg::ALI_PAT_YEL : ali_pkg::ALI_PAT_GRN);
   endproperty
   a_idle: assert property (p_idle) else $error("idle pattern wrong");

   property p_restart;
      slot_tick && next_pat != pat |=> slot == 3'h0 && pat == $past(next_pat);
   endproperty
   a_restart: assert property (p_restart) else $error("no restart");

   property p_step;
      slot_tick && next_pat == pat |=> slot == 3'($past(slot) + 3'h1);
   endproperty
   a_step: assert property (p_step) else $error("slot not stepped");

   property p_ident;
      reg_we && reg_addr == `ALI_OFF_CTRL |=> ##1
         can_id == `ALI_CAN_BASE + 29'($past(reg_wdata[2:1], 2)) + 29'h00000001;
   endproperty
   a_ident: assert property (p_ident) else $error("identifier stale");

   property p_rate;
      reg_we && reg_addr == `ALI_OFF_RATE |=> ##1 can_bit_div == $past(reg_wdata[15:0], 2);
   endproperty
   a_rate: assert property (p_rate) else $error("rate not applied");

   property p_oc;
      ctrl_active && ctrl[`ALI_CTRL_OC] |=> cell_loop_out_a == $past(loop_a_fault);
   endproperty
   a_oc: assert property (p_oc) else $error("loop output wrong");

   property p_sleep;
      !ctrl_active |=> chain_sleep;
   endproperty
   a_sleep: assert property (p_sleep) else $error("chain awake unpowered");

   property p_wake;
      ctrl_active && chain_msg |=> !chain_sleep;
   endproperty
   a_wake: assert property (p_wake) else $error("chain not woken");

   c_yellow: cover property (led_red && led_green);
   c_alt: cover property (pat == ali_pkg::ALI_PAT_ALT && slot == 3'h1);
   c_switch: cover property (slot_tick && next_pat != pat);
   c_wake: cover property (ctrl_active && chain_msg && chain_sleep);
endmodule : ali_indicator

// *** hdl/ali_params.svh ***
`ifndef ALI_PARAMS_SVH
`define ALI_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define ALI_CLK_MHZ 100
`define ALI_SLOT_MS 125
`define ALI_SLOT_CYCLES (`ALI_SLOT_MS * `ALI_CLK_MHZ * 1000)
`define ALI_SLOT_CNT_W 24
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define ALI_OFF_CTRL 8'h00
`define ALI_OFF_RATE 8'h04
`define ALI_OFF_STAT 8'h08
`define ALI_CTRL_EN 0
`define ALI_CTRL_ID_LO 1
`define ALI_CTRL_ID_HI 2
`define ALI_CTRL_TERM 3
`define ALI_CTRL_OC 4
`define ALI_CTRL_RST 5'h01
`define ALI_RATE_RST 16'h0190
`define ALI_ID_RST 2'h0
// arbitrary base for frame identifiers
`define ALI_CAN_BASE 29'h00000100
`define ALI_ASCII_ZERO 8'h30
// ----------------------------------------
// alert inputs, bit 0 highest priority
// ----------------------------------------
`define ALI_AL_W 9
`define ALI_AL_MDEV 0
`define ALI_AL_CELLC 1
`define ALI_AL_THC 2
`define ALI_AL_OVT 3
`define ALI_AL_HVC 4
`define ALI_AL_LVC 5
`define ALI_AL_UNLK 6
`define ALI_AL_BVC 7
`define ALI_AL_DIS 8
// ----------------------------------------
// slot maps, bit n is slot n
// ----------------------------------------
`define ALI_MAP_LONG 8'h3F
`define ALI_MAP_SHORT 8'h03
`define ALI_MAP_EVEN 8'h55
`define ALI_MAP_ODD 8'hAA
`define ALI_MAP_NONE 8'h00
`endif

// *** hdl/ali_pkg.sv ***
package ali_pkg;
   typedef enum logic [2:0] {
      ALI_PAT_OFF = 3'h0,
      ALI_PAT_LRED = 3'h1,
      ALI_PAT_RED = 3'h2,
      ALI_PAT_ALT = 3'h3,
      ALI_PAT_YEL = 3'h4,
      ALI_PAT_GRN = 3'h5
   } ali_pat_t;
endpackage : ali_pkg

// *** hdl/ali_pattern_rom.sv ***
`timescale 1ns/1ps
`include "ali_params.svh"
module ali_pattern_rom (
   input wire logic clk,
   input wire logic rst_n,
   input wire ali_pkg::ali_pat_t pat,
   input wire logic [2:0] slot,
   output logic red,
   output logic green
);
   logic [7:0] map_r;
   logic [7:0] map_g;

   always_comb begin
      map_r = `ALI_MAP_NONE;
      map_g = `ALI_MAP_NONE;
      unique case (pat)
         ali_pkg::ALI_PAT_OFF: begin
         end
         ali_pkg::ALI_PAT_LRED: map_r = `ALI_MAP_LONG;
         ali_pkg::ALI_PAT_RED: map_r = `ALI_MAP_SHORT;
         ali_pkg::ALI_PAT_ALT: begin
            map_r = `ALI_MAP_EVEN;
            map_g = `ALI_MAP_ODD;
         end
         // yellow is both elements lit together
         ali_pkg::ALI_PAT_YEL: begin
            map_r = `ALI_MAP_SHORT;
            map_g = `ALI_MAP_SHORT;
         end
         ali_pkg::ALI_PAT_GRN: map_g = `ALI_MAP_SHORT;
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         red <= 1'b0;
         green <= 1'b0;
      end else begin
         red <= map_r[slot];
         green <= map_g[slot];
      end
   end
endmodule : ali_pattern_rom

// *** tb/ali_far_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// far side: bicolour led and chain devices
// ----------------------------------------
module ali_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic led_red,
   input wire logic led_green,
   input wire logic chain_sleep,
   input wire logic chain_msg,
   output logic [1:0] colour,
   output logic dev_ready
);
   // both elements lit reads as yellow, code 3
   assign colour = {led_green, led_red};
   // sleep wins: a message into a sleeping chain is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_ready <= 1'b0;
      end else if (chain_sleep) begin
         dev_ready <= 1'b0;
      end else if (chain_msg) begin
         dev_ready <= 1'b1;
      end
   end
endmodule : ali_far_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "ali_params.svh"
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic ctrl_active = 1'b0;
   logic [8:0] alert_in = 9'h000;
   logic loop_a_fault = 1'b0;
   logic loop_b_fault = 1'b0;
   logic chain_msg = 1'b0;
   logic [31:0] reg_rdata;
   logic led_red, led_green, can_ext_id, can_term_en, oc_mode, out_a, out_b, chain_sleep;
   logic [28:0] can_id;
   logic [15:0] can_bit_div;
   logic [7:0] prompt_suffix;
   logic [1:0] colour;
   logic dev_ready;
   logic f;
   logic [15:0] last_map = 16'hFFFF;
   logic [31:0] rv;
   logic [31:0] got;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   ali_indicator #(.SLOT_CYCLES(8)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .ctrl_active(ctrl_active), .alert_in(alert_in), .loop_a_fault(loop_a_fault),
      .loop_b_fault(loop_b_fault), .chain_msg(chain_msg), .led_red(led_red),
      .led_green(led_green), .can_id(can_id), .can_ext_id(can_ext_id),
      .can_bit_div(can_bit_div), .can_term_en(can_term_en), .prompt_suffix(prompt_suffix),
      .cell_loop_oc_mode(oc_mode), .cell_loop_out_a(out_a), .cell_loop_out_b(out_b),
      .chain_sleep(chain_sleep));
   ali_far_model far (.clk(clk), .rst_n(rst_n), .led_red(led_red), .led_green(led_green),
      .chain_sleep(chain_sleep), .chain_msg(chain_msg), .colour(colour), .dev_ready(dev_ready));
   always #5 clk = ~clk;
   // slot phase follows the design counter from reset release
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cyc <= 0;
      else cyc <= cyc + 1;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task chk(string name, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr
   task rd(logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   task wait_phase(int p);
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         if (cyc % 8 == p) return;
      end
      failures++;
      $display("[FAIL] slot phase expected %0d seen %0d", p, cyc % 8);
      wrap_up();
   endtask : wait_phase
   // green map in the upper byte, red map in the lower
   function automatic logic [15:0] exp_map(logic [8:0] a);
      for (int i = 0; i < 9; i++) begin
         if (a[i] && i != 7) begin
            case (i)
               0, 3: return 16'h003F;
               1, 2, 6: return 16'hAA55;
               4, 5: return 16'h0003;
               default: return 16'h0303;
            endcase
         end
      end
      return 16'h0300;
   endfunction : exp_map
   // pattern code that the status register should report for a map
   function automatic logic [2:0] exp_code(logic [15:0] m);
      case (m)
         16'h003F: return ali_pkg::ALI_PAT_LRED;
         16'h0003: return ali_pkg::ALI_PAT_RED;
         16'hAA55: return ali_pkg::ALI_PAT_ALT;
         16'h0303: return ali_pkg::ALI_PAT_YEL;
         default: return ali_pkg::ALI_PAT_GRN;
      endcase
   endfunction : exp_code
   // same map as before gives no restart point, so it is skipped
   task check_pat(logic [8:0] a);
      logic [15:0] m;
      m = exp_map(a);
      wait_phase(1);
      @(posedge clk) alert_in <= a;
      wait_phase(6);
      if (m == last_map) return;
      last_map = m;
      for (int s = 0; s < 8; s++) begin
         for (int p = 4; p < 8; p++) begin
            wait_phase(p);
            chk("led colour", {30'h0, m[8+s], m[s]}, {30'h0, colour});
         end
      end
   endtask : check_pat
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hDF96));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("can_id", 32'h101, 32'(can_id));
      chk("can_ext_id", 32'h1, 32'(can_ext_id));
      chk("can_bit_div", 32'h190, 32'(can_bit_div));
      chk("can_term_en", 32'h0, 32'(can_term_en));
      chk("chain_sleep", 32'h1, 32'(chain_sleep));
      rd(8'h00, rv);
      chk("ctrl", 32'h01, rv);
      rd(8'h04, rv);
      chk("rate", 32'h190, rv);
      wr(8'h0C, 32'hFFFFFFFF);
      rd(8'h0C, rv);
      chk("unmapped", 32'h0, rv);
      @(posedge clk) ctrl_active <= 1'b1;
      check_pat(9'h001);
      check_pat(9'h000);
      check_pat(9'h002);
      check_pat(9'h008);
      check_pat(9'h004);
      check_pat(9'h010);
      check_pat(9'h040);
      check_pat(9'h020);
      check_pat(9'h100);
      check_pat(9'h080);
      for (int i = 0; i < 10; i++) check_pat(9'($urandom));
      wr(8'h00, 32'h0);
      settle();
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         chk("led off", 32'h0, 32'(colour));
      end
      for (int i = 0; i < 4; i++) begin
         rv = {27'h0, 1'($urandom), 1'($urandom), 2'(i), 1'b1};
         wr(8'h00, rv);
         settle();
         chk("can_id", 32'h101 + i, 32'(can_id));
         chk("prompt", (i == 0) ? 32'h0 : 32'h31 + i, 32'(prompt_suffix));
         chk("can_term_en", 32'(rv[3]), 32'(can_term_en));
         chk("oc_mode", 32'(rv[4]), 32'(oc_mode));
         f = 1'($urandom);
         @(posedge clk);
         loop_a_fault <= f;
         loop_b_fault <= ~f;
         settle();
         chk("loop a", {31'h0, rv[4] ? f : ~f}, 32'(out_a));
         chk("loop b", {31'h0, rv[4] ? ~f : f}, 32'(out_b));
         rd(8'h00, got);
         chk("ctrl", {27'h0, rv[4:3], 2'(i), 1'b1}, got);
      end
      rv = 32'($urandom) & 32'h0000FFFF;
      wr(8'h04, rv);
      settle();
      chk("can_bit_div", rv, 32'(can_bit_div));
      @(posedge clk) chain_msg <= 1'b1;
      repeat (3) @(posedge clk);
      chain_msg <= 1'b0;
      #1;
      chk("chain_sleep", 32'h0, 32'(chain_sleep));
      chk("dev_ready", 32'h1, 32'(dev_ready));
      @(posedge clk) ctrl_active <= 1'b0;
      settle();
      chk("chain_sleep", 32'h1, 32'(chain_sleep));
      chk("dev_ready", 32'h0, 32'(dev_ready));
      chk("led off", 32'h0, 32'(colour));
      chk("loops off", 32'h0, {30'h0, out_a, out_b});
      rd(8'h08, got);
      chk("status", {23'h000000, 3'h4, 3'h0, exp_code(last_map)}, got & 32'h000001C7);
      wrap_up();
   end
endmodule : testbench
